// >>> inc/slti_regs.svh
`ifndef SLTI_REGS_SVH
`define SLTI_REGS_SVH

// Byte addresses on the APB bus.
`define SLTI_ADDR_LSB_CTRL   12'h160
`define SLTI_ADDR_CFG        12'h164
`define SLTI_ADDR_STAT       12'h168

// Reset values.
`define SLTI_LSB_CTRL_RST    8'h00
`define SLTI_CFG_RST         8'h00

// Field positions in lsb_ctrl_reg.
`define SLTI_LSB_MARKER_EN   0

// Field positions in the configuration register.
`define SLTI_CFG_CAL_EN      0
`define SLTI_CFG_W8          1
`define SLTI_CFG_DECIM       2
`define SLTI_CFG_RX_ON       3

// Field positions in the status register.
`define SLTI_STAT_ACTIVE     0
`define SLTI_STAT_MARKER     1
`define SLTI_STAT_CS_LO      2

// Control-bit count announced in the lane alignment data.
`define SLTI_ILA_CS_VALUE    2'h0

`endif

// >>> inc/slti_pkg.sv
package slti_pkg;

    typedef logic [7:0] slti_reg_t;

    typedef enum logic [1:0] {
        SLTI_LSB_DATA   = 2'b00,
        SLTI_LSB_MARKER = 2'b01,
        SLTI_LSB_CAL    = 2'b10
    } slti_lsb_src_e;

endpackage

// >>> core/slti_top.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "slti_regs.svh"

// Notes on behaviour
// - With marker enabled, the marker receiver on and decimation off, the external timestamp rides in every output sample LSB.
// - Insertion works only without decimation; decimating modes never insert.
// - Timestamp wins over the calibration-state flag on the LSB.
// - Marker is delayed exactly as long as the analog samples.
// - In 8-bit modes the LSB of the 8-bit sample is replaced, 7 bits stay.
// - In 12-bit modes the LSB of the 12-bit sample is replaced, 11 bits stay.
// - The control-bit count announced in lane alignment data is always zero.
// - Marker control register at 0x160 resets to 0x00; bits 7 to 1 reserved.
module slti_top
    import slti_pkg::*;
#(
    parameter int SAMPLE_W   = 12,
    parameter int MARKER_DLY = 6
) (
    // Clock and reset.
    input  wire logic                MCLK_I,
    input  wire logic                RST_I,
    // APB slave.
    input  wire logic                PSEL_I,
    input  wire logic                PENABLE_I,
    input  wire logic                PWRITE_I,
    input  wire logic [11:0]         PADDR_I,
    input  wire logic [31:0]         PWDATA_I,
    output logic      [31:0]         PRDATA_O,
    output logic                     PREADY_O,
    output logic                     PSLVERR_O,
    // Sample stream from the converter pipeline.
    input  wire logic [SAMPLE_W-1:0] SAMPLE_I,
    input  wire logic                SAMPLE_VALID_I,
    input  wire logic                CAL_STATE_I,
    // External timestamp pin.
    input  wire logic                MARKER_I,
    // Toward the transport layer.
    output logic      [SAMPLE_W-1:0] TX_SAMPLE_O,
    output logic                     TX_VALID_O,
    output logic      [1:0]          ILA_CS_O
);

    typedef struct packed {
        slti_reg_t               lsb_ctrl_reg;
        slti_reg_t               cfg_reg;
        logic                    sync1;
        logic                    sync2;
        logic [MARKER_DLY-1:0]   dly;
        logic [31:0]             rdata;
        logic                    rerr;
        logic [SAMPLE_W-1:0]     tx_sample;
        logic                    tx_valid;
    } slti_state_s;

    slti_state_s   st_reg;
    slti_state_s   st_next;
    logic          setup;
    logic          access;
    logic          hit_ctrl;
    logic          hit_cfg;
    logic          hit_stat;
    logic          marker_rx;
    logic          marker_aligned;
    logic          insert_on;
    slti_lsb_src_e src;
    logic [SAMPLE_W-1:0] smp;
    logic [7:0]    stat;

    always_comb begin
        setup    = PSEL_I && !PENABLE_I;
        access   = PSEL_I && PENABLE_I;
        hit_ctrl = (PADDR_I == `SLTI_ADDR_LSB_CTRL);
        hit_cfg  = (PADDR_I == `SLTI_ADDR_CFG);
        hit_stat = (PADDR_I == `SLTI_ADDR_STAT);
        // A receiver left off delivers a quiet low marker.
        marker_rx = st_reg.sync2 && st_reg.cfg_reg[`SLTI_CFG_RX_ON];
        // The tap equals the analog path minus the two synchroniser stages.
        marker_aligned = st_reg.dly[MARKER_DLY-1];
        insert_on = st_reg.lsb_ctrl_reg[`SLTI_LSB_MARKER_EN]
                    && !st_reg.cfg_reg[`SLTI_CFG_DECIM];
        if (insert_on) begin
            src = SLTI_LSB_MARKER;
        end else if (st_reg.cfg_reg[`SLTI_CFG_CAL_EN]) begin
            src = SLTI_LSB_CAL;
        end else begin
            src = SLTI_LSB_DATA;
        end
        stat = 8'h00;
        stat[`SLTI_STAT_ACTIVE] = insert_on;
        stat[`SLTI_STAT_MARKER] = marker_rx;
        stat[`SLTI_STAT_CS_LO +: 2] = `SLTI_ILA_CS_VALUE;

        smp = SAMPLE_I;
        if (st_reg.cfg_reg[`SLTI_CFG_W8]) begin
            // Eight-bit samples sit in the low byte; upper bits stay clear.
            smp = {{(SAMPLE_W-8){1'b0}}, SAMPLE_I[7:0]};
        end
        case (src)
            SLTI_LSB_MARKER: smp[0] = marker_aligned;
            SLTI_LSB_CAL:    smp[0] = CAL_STATE_I;
            default:         smp[0] = smp[0];
        endcase

        st_next = st_reg;
        st_next.sync1 = MARKER_I;
        st_next.sync2 = st_reg.sync1;
        if (MARKER_DLY > 1) begin
            st_next.dly = {st_reg.dly[MARKER_DLY-2:0], marker_rx};
        end else begin
            st_next.dly = {MARKER_DLY{marker_rx}};
        end
        st_next.tx_valid = SAMPLE_VALID_I;
        if (SAMPLE_VALID_I) begin
            st_next.tx_sample = smp;
        end

        // Read data is latched in the setup cycle so it comes from a flop.
        if (setup) begin
            st_next.rerr  = !(hit_ctrl || hit_cfg || hit_stat);
            st_next.rdata = 32'h0000_0000;
            if (hit_ctrl) begin
                st_next.rdata = {24'h00_0000, st_reg.lsb_ctrl_reg};
            end else if (hit_cfg) begin
                st_next.rdata = {24'h00_0000, st_reg.cfg_reg};
            end else if (hit_stat) begin
                st_next.rdata = {24'h00_0000, stat};
            end
        end
        if (access && PWRITE_I) begin
            if (hit_ctrl) begin
                // Reserved bits keep whatever software writes.
                st_next.lsb_ctrl_reg = PWDATA_I[7:0];
            end else if (hit_cfg) begin
                st_next.cfg_reg = {4'h0, PWDATA_I[3:0]};
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            st_reg              <= '0;
            st_reg.lsb_ctrl_reg <= `SLTI_LSB_CTRL_RST;
            st_reg.cfg_reg      <= `SLTI_CFG_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign PRDATA_O    = st_reg.rdata;
    assign PREADY_O    = 1'b1;
    assign PSLVERR_O   = access && st_reg.rerr;
    assign TX_SAMPLE_O = st_reg.tx_sample;
    assign TX_VALID_O  = st_reg.tx_valid;
    // The inserted bit is never advertised to the receiver.
    assign ILA_CS_O    = `SLTI_ILA_CS_VALUE;

endmodule

// >>> sim/slti_chk.sv
`timescale 1ns/1ps
module slti_chk #(parameter int SAMPLE_W = 12) (
    input wire logic MCLK_I, RST_I, PSEL_I, PENABLE_I, PSLVERR_O,
    input wire logic SAMPLE_VALID_I, TX_VALID_O,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic [SAMPLE_W-1:0] SAMPLE_I, TX_SAMPLE_O,
    input wire logic [1:0] ILA_CS_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    wire acc = PSEL_I && PENABLE_I;
    property p_ila; ILA_CS_O == 2'h0; endproperty
    a_ila: assert property (p_ila) else $error("cs count");
    property p_von; SAMPLE_VALID_I |=> TX_VALID_O; endproperty
    a_von: assert property (p_von) else $error("lost");
    property p_voff; !SAMPLE_VALID_I |=> !TX_VALID_O; endproperty
    a_voff: assert property (p_voff) else $error("extra");
    property p_hold; !SAMPLE_VALID_I |=> $stable(TX_SAMPLE_O); endproperty
    a_hold: assert property (p_hold) else $error("moved");
    property p_dat; SAMPLE_VALID_I |=> TX_SAMPLE_O[7:1] == $past(SAMPLE_I[7:1]); endproperty
    a_dat: assert property (p_dat) else $error("data");
    property p_ok; acc && PADDR_I == 12'h160 |-> !PSLVERR_O; endproperty
    a_ok: assert property (p_ok) else $error("refused");
    property p_rd; acc && PADDR_I == 12'h160 |-> PRDATA_O[31:8] == 24'h0; endproperty
    a_rd: assert property (p_rd) else $error("upper");
    property p_gap; acc && PADDR_I == 12'h170 |-> PSLVERR_O; endproperty
    a_gap: assert property (p_gap) else $error("hole");
endmodule
bind slti_top slti_chk #(.SAMPLE_W(SAMPLE_W)) u_slti_chk (.*);

// >>> sim/slti_rx.sv
`timescale 1ns/1ps
module slti_rx (
    input  wire logic        clk_i,
    input  wire logic        vld_i,
    input  wire logic [11:0] smp_i,
    output logic      [11:0] got_o
);
    // Words between strobes are not trusted, so only strobed ones are kept.
    always_ff @(posedge clk_i) if (vld_i) got_o <= smp_i;
endmodule

// >>> sim/sample_lsb_timestamp_insert_test.sv
`timescale 1ns/1ps
module sample_lsb_timestamp_insert_test;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, vld = 0, cal = 1, mrk = 0;
    logic prdy, perr, tvld, er;
    logic [11:0] adr = 0, smp = 0, tx, got;
    logic [31:0] pwd = 0, prd, rd;
    int n_fail = 0, checked = 0, cyc = 0;
    slti_top #(.MARKER_DLY(3)) u_slti_top (.MCLK_I(clk), .RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(adr), .PWDATA_I(pwd), .PRDATA_O(prd),
        .PREADY_O(prdy), .PSLVERR_O(perr), .SAMPLE_I(smp), .SAMPLE_VALID_I(vld),
        .CAL_STATE_I(cal), .MARKER_I(mrk), .TX_SAMPLE_O(tx), .TX_VALID_O(tvld), .ILA_CS_O());
    slti_rx u_slti_rx (.clk_i(clk), .vld_i(tvld), .smp_i(tx), .got_o(got));
    initial forever #4 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk) {psel, pwr, adr, pwd} <= {1'b1, w, a, d};
        @(posedge clk) pen <= 1;
        do @(posedge clk); while (prdy !== 1'b1);
        {er, rd} = {perr, prd};
        {psel, pen} <= 2'b0;
    endtask
    task automatic put(input logic [11:0] s, e);
        @(posedge clk) {vld, smp} <= {1'b1, s};
        @(posedge clk) vld <= 0;
        @(posedge clk);
        @(negedge clk) chk("sample", 32'(got), 32'(e));
    endtask
    task automatic mk(input logic v);
        @(posedge clk) mrk <= v;
        repeat (12) @(posedge clk);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) if (++cyc == 3000) begin
        n_fail++;
        final_report;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        apb(0, 12'h160, 0);
        chk("ctrl", rd, 0);
        chk("ctrl err", 32'(er), 0);
        apb(1, 12'h160, 32'hff);
        apb(0, 12'h160, 0);
        chk("ctrl", rd, 32'hff);
        apb(0, 12'h170, 0);
        chk("hole data", rd, 0);
        chk("hole err", 32'(er), 1);
        apb(1, 12'h160, 0);
        put(12'habc, 12'habc);
        apb(1, 12'h164, 32'h08);
        apb(1, 12'h160, 1);
        @(posedge clk) {mrk, vld} <= 2'b11;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            @(negedge clk) chk("lsb", 32'(tx[0]), 32'(i >= 5));
        end
        put(12'hf56, 12'hf57);
        mk(0);
        apb(1, 12'h164, 32'h09);
        put(12'h0aa, 12'h0aa);
        apb(1, 12'h160, 0);
        put(12'h0aa, 12'h0ab);
        mk(1);
        apb(1, 12'h160, 1);
        apb(1, 12'h164, 32'h0c);
        put(12'h0aa, 12'h0aa);
        apb(1, 12'h164, 32'h0a);
        put(12'hf56, 12'h057);
        apb(0, 12'h164, 0);
        chk("cfg", rd, 32'h0a);
        apb(0, 12'h168, 0);
        chk("status", rd, 32'h03);
        final_report;
    end
endmodule
